/* File: src/plr_consts.vh */
// Offsets, field positions and reset values of the PLL loop configuration registers
`ifndef PLR_CONSTS_VH
`define PLR_CONSTS_VH

`define PLR_ADDR_W 10
`define PLR_OFS_LOOP_CTRL 10'h010
`define PLR_OFS_REF_LO 10'h011
`define PLR_OFS_REF_HI 10'h012
`define PLR_OFS_SWALLOW 10'h013
`define PLR_OFS_MAIN_LO 10'h014
`define PLR_OFS_MAIN_HI 10'h015

`define PLR_RST_LOOP_CTRL 8'h7D
`define PLR_RST_REF_LO 8'h01
`define PLR_RST_REF_HI 8'h00
`define PLR_RST_SWALLOW 8'h00
`define PLR_RST_MAIN_LO 8'h03
`define PLR_RST_MAIN_HI 8'h00

`define PLR_MASK_REF_HI 8'h3F
`define PLR_MASK_SWALLOW 8'h3F
`define PLR_MASK_MAIN_HI 8'h1F

`define PLR_BIT_POLARITY 7
`define PLR_CUR_HI 6
`define PLR_CUR_LO 4
`define PLR_MODE_HI 3
`define PLR_MODE_LO 2
`define PLR_PD_HI 1
`define PLR_PD_LO 0

`define PLR_MODE_HIZ 2'h0
`define PLR_MODE_SOURCE 2'h1
`define PLR_MODE_SINK 2'h2
`define PLR_MODE_NORMAL 2'h3

`define PLR_PD_ASYNC 2'h1
`define PLR_PD_SYNC 2'h3

`endif

/* File: src/plr_loop_config_regs.v */
// PLL loop configuration register bank with decoded control outputs
`timescale 1ns/100ps
`default_nettype none
`include "plr_consts.vh"

module plr_loop_config_regs (
   input wire clock_i,
   input wire nrst_i,
   input wire wr_en_i,
   input wire rd_en_i,
   input wire [9:0] addr_i,
   input wire [7:0] wdata_i,
   output wire [7:0] rdata_o,
   output wire rvalid_o,
   output wire vco_sense_inverted_o,
   output wire [2:0] pump_current_select_o,
   output wire pump_hiz_o,
   output wire pump_force_source_o,
   output wire pump_force_sink_o,
   output wire pump_normal_o,
   output wire pll_async_pd_o,
   output wire pll_sync_pd_o,
   output wire [13:0] ref_divide_o,
   output wire [5:0] swallow_count_o,
   output wire [12:0] main_count_o
);

   // Reset values and codes at their own widths
   localparam [7:0] RST_LOOP_CTRL = `PLR_RST_LOOP_CTRL;
   localparam [7:0] RST_REF_LO = `PLR_RST_REF_LO;
   localparam [7:0] RST_REF_HI = `PLR_RST_REF_HI;
   localparam [7:0] RST_SWALLOW = `PLR_RST_SWALLOW;
   localparam [7:0] RST_MAIN_LO = `PLR_RST_MAIN_LO;
   localparam [7:0] RST_MAIN_HI = `PLR_RST_MAIN_HI;
   localparam [1:0] MODE_NORMAL = `PLR_MODE_NORMAL;
   localparam [1:0] PD_ASYNC = `PLR_PD_ASYNC;
   localparam [1:0] PD_SYNC = `PLR_PD_SYNC;

   // Stored fields
   reg [7:0] loop_ctrl_ff;
   reg [7:0] ref_lo_ff;
   reg [5:0] ref_hi_ff;
   reg [5:0] swallow_ff;
   reg [7:0] main_lo_ff;
   reg [4:0] main_hi_ff;
   reg [7:0] nxt_loop_ctrl;
   reg [7:0] nxt_ref_lo;
   reg [5:0] nxt_ref_hi;
   reg [5:0] nxt_swallow;
   reg [7:0] nxt_main_lo;
   reg [4:0] nxt_main_hi;

   // Read answer and decoded controls
   reg [7:0] rdata_ff;
   reg [7:0] nxt_rdata;
   reg rvalid_ff;
   reg inv_ff;
   reg [3:0] mode_hot_ff;
   reg apd_ff;
   reg spd_ff;
   reg nxt_inv;
   reg nxt_apd;
   reg nxt_spd;

   // Offset decode
   wire hit_loop_ctrl;
   wire hit_ref_lo;
   wire hit_ref_hi;
   wire hit_swallow;
   wire hit_main_lo;
   wire hit_main_hi;
   wire [1:0] mode_code;
   wire [1:0] pd_code;

   assign hit_loop_ctrl = (addr_i == `PLR_OFS_LOOP_CTRL);
   assign hit_ref_lo = (addr_i == `PLR_OFS_REF_LO);
   assign hit_ref_hi = (addr_i == `PLR_OFS_REF_HI);
   assign hit_swallow = (addr_i == `PLR_OFS_SWALLOW);
   assign hit_main_lo = (addr_i == `PLR_OFS_MAIN_LO);
   assign hit_main_hi = (addr_i == `PLR_OFS_MAIN_HI);
   assign mode_code = loop_ctrl_ff[`PLR_MODE_HI:`PLR_MODE_LO];
   assign pd_code = loop_ctrl_ff[`PLR_PD_HI:`PLR_PD_LO];

   // Write strobes per register; unmapped offsets hit none
   wire wr_loop_ctrl;
   wire wr_ref_lo;
   wire wr_ref_hi;
   wire wr_swallow;
   wire wr_main_lo;
   wire wr_main_hi;
   assign wr_loop_ctrl = wr_en_i & hit_loop_ctrl;
   assign wr_ref_lo = wr_en_i & hit_ref_lo;
   assign wr_ref_hi = wr_en_i & hit_ref_hi;
   assign wr_swallow = wr_en_i & hit_swallow;
   assign wr_main_lo = wr_en_i & hit_main_lo;
   assign wr_main_hi = wr_en_i & hit_main_hi;

   // Loop control: polarity, pump current, pump mode, power-down
   always @* begin
      nxt_loop_ctrl = loop_ctrl_ff;
      if (wr_loop_ctrl) begin
         nxt_loop_ctrl = wdata_i;
      end
   end

   always @(posedge clock_i) begin
      if (!nrst_i) begin
         loop_ctrl_ff <= RST_LOOP_CTRL;
      end else begin
         loop_ctrl_ff <= nxt_loop_ctrl;
      end
   end

   // Reference divider, low byte
   always @* begin
      nxt_ref_lo = ref_lo_ff;
      if (wr_ref_lo) begin
         nxt_ref_lo = wdata_i;
      end
   end

   always @(posedge clock_i) begin
      if (!nrst_i) begin
         ref_lo_ff <= RST_REF_LO;
      end else begin
         ref_lo_ff <= nxt_ref_lo;
      end
   end

   // Reference divider, upper six bits
   always @* begin
      nxt_ref_hi = ref_hi_ff;
      if (wr_ref_hi) begin
         nxt_ref_hi = wdata_i[5:0];
      end
   end

   always @(posedge clock_i) begin
      if (!nrst_i) begin
         ref_hi_ff <= RST_REF_HI[5:0];
      end else begin
         ref_hi_ff <= nxt_ref_hi;
      end
   end

   // Swallow counter, six bits
   always @* begin
      nxt_swallow = swallow_ff;
      if (wr_swallow) begin
         nxt_swallow = wdata_i[5:0];
      end
   end

   always @(posedge clock_i) begin
      if (!nrst_i) begin
         swallow_ff <= RST_SWALLOW[5:0];
      end else begin
         swallow_ff <= nxt_swallow;
      end
   end

   // Main counter, low byte
   always @* begin
      nxt_main_lo = main_lo_ff;
      if (wr_main_lo) begin
         nxt_main_lo = wdata_i;
      end
   end

   always @(posedge clock_i) begin
      if (!nrst_i) begin
         main_lo_ff <= RST_MAIN_LO;
      end else begin
         main_lo_ff <= nxt_main_lo;
      end
   end

   // Main counter, upper five bits
   always @* begin
      nxt_main_hi = main_hi_ff;
      if (wr_main_hi) begin
         nxt_main_hi = wdata_i[4:0];
      end
   end

   always @(posedge clock_i) begin
      if (!nrst_i) begin
         main_hi_ff <= RST_MAIN_HI[4:0];
      end else begin
         main_hi_ff <= nxt_main_hi;
      end
   end

   // Readback, unused bits and unmapped offsets read zero
   always @* begin
      nxt_rdata = 8'h00;
      if (rd_en_i) begin
         case (addr_i)
            `PLR_OFS_LOOP_CTRL: begin
               nxt_rdata = loop_ctrl_ff;
            end
            `PLR_OFS_REF_LO: begin
               nxt_rdata = ref_lo_ff;
            end
            `PLR_OFS_REF_HI: begin
               nxt_rdata = {2'h0, ref_hi_ff};
            end
            `PLR_OFS_SWALLOW: begin
               nxt_rdata = {2'h0, swallow_ff};
            end
            `PLR_OFS_MAIN_LO: begin
               nxt_rdata = main_lo_ff;
            end
            `PLR_OFS_MAIN_HI: begin
               nxt_rdata = {3'h0, main_hi_ff};
            end
            default: begin
               nxt_rdata = 8'h00;
            end
         endcase
      end
   end

   always @(posedge clock_i) begin
      if (!nrst_i) begin
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         rvalid_ff <= rd_en_i;
      end
   end

   // Power-down codes 0 and 2 both mean normal operation
   always @* begin
      nxt_inv = loop_ctrl_ff[`PLR_BIT_POLARITY];
      nxt_apd = 1'b0;
      nxt_spd = 1'b0;
      case (pd_code)
         PD_ASYNC: begin
            nxt_apd = 1'b1;
         end
         PD_SYNC: begin
            nxt_spd = 1'b1;
         end
         default: begin
            nxt_apd = 1'b0;
            nxt_spd = 1'b0;
         end
      endcase
   end

   // Loop sense flag
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         inv_ff <= 1'b0;
      end else begin
         inv_ff <= nxt_inv;
      end
   end

   // Power-down flags
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         apd_ff <= 1'b1;
         spd_ff <= 1'b0;
      end else begin
         apd_ff <= nxt_apd;
         spd_ff <= nxt_spd;
      end
   end

   // One flag per pump mode code, exactly one high
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_mode
         localparam [1:0] CODE = g;
         always @(posedge clock_i) begin
            if (!nrst_i) begin
               mode_hot_ff[g] <= (CODE == MODE_NORMAL);
            end else begin
               mode_hot_ff[g] <= (mode_code == CODE);
            end
         end
      end
   endgenerate

   // Outputs
   assign rdata_o = rdata_ff;
   assign rvalid_o = rvalid_ff;
   assign vco_sense_inverted_o = inv_ff;
   assign pump_current_select_o = loop_ctrl_ff[`PLR_CUR_HI:`PLR_CUR_LO];
   assign pump_hiz_o = mode_hot_ff[0];
   assign pump_force_source_o = mode_hot_ff[1];
   assign pump_force_sink_o = mode_hot_ff[2];
   assign pump_normal_o = mode_hot_ff[3];
   assign pll_async_pd_o = apd_ff;
   assign pll_sync_pd_o = spd_ff;
   assign ref_divide_o = {ref_hi_ff, ref_lo_ff};
   assign swallow_count_o = swallow_ff;
   assign main_count_o = {main_hi_ff, main_lo_ff};

endmodule

`default_nettype wire

/* File: testbench/plr_loop_config_regs_tb.sv */
// Testbench for the PLL loop configuration register bank
`timescale 1ns/100ps
`default_nettype none
module plr_loop_config_regs_tb;
   logic clock_i = 0, nrst_i = 0, wr_en_i = 0, rd_en_i = 0, rvalid_o, vco_sense_inverted_o;
   logic pump_hiz_o, pump_force_source_o, pump_force_sink_o, pump_normal_o, pll_async_pd_o, pll_sync_pd_o;
   logic [9:0] addr_i = 0;
   logic [7:0] wdata_i = 0, rdata_o;
   logic [2:0] pump_current_select_o;
   logic [13:0] ref_divide_o;
   logic [5:0] swallow_count_o;
   logic [12:0] main_count_o;
   int errors = 0, checks_done = 0, cyc = 0;
   plr_loop_config_regs DUT (
      .clock_i(clock_i), .nrst_i(nrst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .vco_sense_inverted_o(vco_sense_inverted_o),
      .pump_current_select_o(pump_current_select_o), .pump_hiz_o(pump_hiz_o),
      .pump_force_source_o(pump_force_source_o), .pump_force_sink_o(pump_force_sink_o),
      .pump_normal_o(pump_normal_o), .pll_async_pd_o(pll_async_pd_o), .pll_sync_pd_o(pll_sync_pd_o),
      .ref_divide_o(ref_divide_o), .swallow_count_o(swallow_count_o), .main_count_o(main_count_o));
   initial forever #25 clock_i = ~clock_i;
   task chk(input logic [15:0] s, e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task wr(input logic [9:0] a, input logic [7:0] d);
      @(negedge clock_i) {wr_en_i, addr_i, wdata_i} = {1'b1, a, d};
      @(negedge clock_i) wr_en_i = 0;
      @(negedge clock_i);
   endtask
   task rd(input logic [9:0] a, input logic [7:0] e);
      @(negedge clock_i) {rd_en_i, addr_i} = {1'b1, a};
      @(negedge clock_i) rd_en_i = 0;
      chk({rvalid_o, rdata_o}, {1'b1, e});
      @(negedge clock_i) chk({rvalid_o, rdata_o}, 9'h000);
   endtask
   task do_reset;
      nrst_i = 0;
      repeat (5) @(negedge clock_i);
      nrst_i = 1;
   endtask
   task t_reset;
      logic [7:0] rv [6] = '{8'h7D, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00};
      for (int i = 0; i < 6; i++) rd(10'h010 + i, rv[i]);
      chk(ref_divide_o, 14'h0001);
      chk(main_count_o, 13'h0003);
   endtask
   task t_ctrl;
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         d = {i[0], i[2:0], i[1:0], i[1:0]};
         wr(10'h010, d);
         chk(vco_sense_inverted_o, i[0]);
         chk(pump_current_select_o, i[2:0]);
         chk({pump_hiz_o, pump_force_source_o, pump_force_sink_o, pump_normal_o}, 4'h8 >> i[1:0]);
         chk({pll_async_pd_o, pll_sync_pd_o}, {i[1:0] == 1, i[1:0] == 3});
         rd(10'h010, d);
      end
      wr(10'h010, 8'h7D);
   endtask
   task t_div;
      for (int i = 1; i < 7; i++) wr(10'h010 + i, 8'hFF);
      chk(ref_divide_o, 14'h3FFF);
      chk(swallow_count_o, 6'h3F);
      chk(main_count_o, 13'h1FFF);
      rd(10'h012, 8'h3F);
      rd(10'h013, 8'h3F);
      rd(10'h015, 8'h1F);
      rd(10'h016, 8'h00);
   endtask
   task report_and_stop;
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         report_and_stop;
      end
   end
   initial begin
      do_reset;
      t_reset;
      t_ctrl;
      t_div;
      do_reset;
      t_reset;
      report_and_stop;
   end
endmodule
bind plr_loop_config_regs plr_props u_props (
   .clock_i(clock_i), .nrst_i(nrst_i), .wr_en_i(wr_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .vco_sense_inverted_o(vco_sense_inverted_o), .pump_current_select_o(pump_current_select_o),
   .pump_hiz_o(pump_hiz_o), .pump_force_source_o(pump_force_source_o), .pump_force_sink_o(pump_force_sink_o),
   .pump_normal_o(pump_normal_o), .pll_async_pd_o(pll_async_pd_o), .pll_sync_pd_o(pll_sync_pd_o),
   .ref_divide_o(ref_divide_o));
`default_nettype wire

/* File: testbench/plr_props_properties.sv */
// Checker for the PLL loop configuration register bank
`timescale 1ns/100ps
`default_nettype none
module plr_props (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic wr_en_i,
   input wire logic [9:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic vco_sense_inverted_o,
   input wire logic [2:0] pump_current_select_o,
   input wire logic pump_hiz_o,
   input wire logic pump_force_source_o,
   input wire logic pump_force_sink_o,
   input wire logic pump_normal_o,
   input wire logic pll_async_pd_o,
   input wire logic pll_sync_pd_o,
   input wire logic [13:0] ref_divide_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   sequence s_ctl;
      wr_en_i && addr_i == 10'h010;
   endsequence
   a_pol_wr: assert property (s_ctl |-> ##2 vco_sense_inverted_o == $past(wdata_i[7], 2))
      else $error("polarity wrong");
   a_cur_wr: assert property (s_ctl |=> pump_current_select_o == $past(wdata_i[6:4]))
      else $error("pump current wrong");
   a_mode_wr: assert property (s_ctl |-> ##2 {pump_hiz_o, pump_force_source_o, pump_force_sink_o,
      pump_normal_o} == 4'h8 >> $past(wdata_i[3:2], 2)) else $error("pump mode wrong");
   a_pd_wr: assert property (s_ctl |-> ##2 {pll_async_pd_o, pll_sync_pd_o} ==
      {$past(wdata_i[1:0], 2) == 2'h1, $past(wdata_i[1:0], 2) == 2'h3}) else $error("power-down wrong");
   a_ref_lo: assert property (wr_en_i && addr_i == 10'h011 |=> ref_divide_o[7:0] == $past(wdata_i))
      else $error("ref low wrong");
   a_ref_hi: assert property (wr_en_i && addr_i == 10'h012 |=> ref_divide_o[13:8] == $past(wdata_i[5:0]))
      else $error("ref high wrong");
   a_ref_rst: assert property ($rose(nrst_i) |-> ref_divide_o == 14'h0001)
      else $error("ref reset wrong");
   a_flag_rst: assert property ($rose(nrst_i) |-> pump_normal_o && pll_async_pd_o && !vco_sense_inverted_o)
      else $error("flag reset wrong");
endmodule
`default_nettype wire
